// file: logic/rsc_regs.svh
// Functional notes
// - Recompute map check while check enable set.
// - Check covers 02h..31h, MSB first.
// - Mode bit selects check polynomial.
// - 16-bit check value in read-only register.
// - Every check pass seeds with all ones.
// - Check value change sets map-changed flag.
// - Status read or null reply clears flag.
// - Output enable bit makes output pin active.
// - Enabled output pin drives level bit push-pull.
// - Any reset restores defaults, converter disabled.
// - No conversion data until converter re-enabled.
// - Data-ready rises after power-on; early traffic ignored.
// - Long low pin pulse holds reset until high.
// - Host waits acquisition time after pin release.
// - Reset command is 0011h in word one.
// - Reset command acts only on complete frame.
// - A frame is exactly five words.
// - Reset follows latch; host waits acquisition time.
// - Host configures in order before main clock.
// - Supply-fail latched; poll until it reads zero.
// - Status readable by null reply and read.
// - Short low pin pulse synchronizes, not resets.
`ifndef RSC_REGS_SVH
`define RSC_REGS_SVH

// Device register addresses.
`define RSC_ADDR_ID 6'h00
`define RSC_ADDR_STATUS 6'h01
`define RSC_ADDR_MODE 6'h02
`define RSC_ADDR_CLOCK 6'h03
`define RSC_ADDR_CFG 6'h04
`define RSC_ADDR_CONV 6'h05
`define RSC_ADDR_CRC_FIRST 6'h02
`define RSC_ADDR_CRC_LAST 6'h31
`define RSC_ADDR_CHECK 6'h3E

// Field positions.
`define RSC_MODE_CRC_EN 0
`define RSC_MODE_CRC_TYPE 1
`define RSC_CFG_OUT_EN 0
`define RSC_CFG_OUT_LVL 1
`define RSC_CONV_EN 0
`define RSC_CONV_FREQ_LSB 4
`define RSC_STAT_MAP_CHG 0
`define RSC_STAT_SECONDARY_SUPPLY_FAIL 1

// Reset values; the identity word is arbitrary.
`define RSC_RST_WORD 16'h0000
`define RSC_RST_CLOCK 16'h0003
`define RSC_RST_CHECK 16'h0000
`define RSC_ID_VALUE 16'h5A01

// Commands and check constants.
`define RSC_CMD_NULL 16'h0000
`define RSC_CMD_RESET 16'h0011
`define RSC_CMD_READ_TOP 3'h5
`define RSC_CMD_WRITE_TOP 3'h3
`define RSC_CRC_SEED 16'hFFFF
`define RSC_POLY_CCITT 16'h1021
`define RSC_POLY_ANSI 16'h8005
`define RSC_WORD_BITS 16
`define RSC_FRAME_WORDS 5

// Timing in nanoseconds and derived clock counts.
`define RSC_CLK_PERIOD_NS 10
`define RSC_POR_NS 1000
`define RSC_POR_CYCLES ((`RSC_POR_NS + `RSC_CLK_PERIOD_NS - 1) / `RSC_CLK_PERIOD_NS)
`define RSC_RESET_LOW_WIDTH_NS 2000
`define RSC_RESET_LOW_CYCLES (`RSC_RESET_LOW_WIDTH_NS / `RSC_CLK_PERIOD_NS)
`define RSC_SYNC_MIN_CYCLES 2
`define RSC_REG_ACQ_NS 500
`define RSC_REG_ACQ_CYCLES ((`RSC_REG_ACQ_NS + `RSC_CLK_PERIOD_NS - 1) / `RSC_CLK_PERIOD_NS)
`define RSC_SCLK_HALF 8
`define RSC_FRAME_GAP 8

// Host command port addresses and bits.
`define RSC_HADDR_CMD 4'h0
`define RSC_HADDR_DATA 4'h1
`define RSC_HADDR_RESP 4'h2
`define RSC_HADDR_STAT 4'h3
`define RSC_HADDR_PIN 4'h4
`define RSC_HSTAT_BUSY 0
`define RSC_HSTAT_DATA_READY_N_N 1
`define RSC_HSTAT_PIN_LOW 2

`endif

// file: logic/rsc_pkg.sv
package rsc_pkg;
  // One serial word.
  typedef logic [15:0] rsc_word_t;
  // Host frame engine states.
  typedef enum logic [1:0] {
    RSC_H_IDLE,
    RSC_H_SHIFT,
    RSC_H_SETTLE
  } rsc_host_state_t;
endpackage : rsc_pkg

// file: logic/rsc_link_if.sv
`timescale 1ns/100ps
interface rsc_link_if;
  logic sclk; // Serial clock, made by the host.
  logic cs_n; // Frame select, active low.
  logic mosi; // Host to device data.
  logic miso; // Device to host data.
  logic miso_oe; // High while the device drives miso.
  logic sync_reset_n; // Sync and reset pin, active low.
  logic data_ready_n; // Data-ready pin, active low.
  logic general_output_pin; // General output level.
  logic general_output_oe; // High while the output is driven.
  modport device (input sclk, cs_n, mosi, sync_reset_n,
    output miso, miso_oe, data_ready_n, general_output_pin,
    general_output_oe);
  modport host (output sclk, cs_n, mosi, sync_reset_n,
    input miso, miso_oe, data_ready_n, general_output_pin,
    general_output_oe);
endinterface : rsc_link_if

// file: logic/rsc_device.sv
`timescale 1ns/100ps
`include "rsc_regs.svh"
module rsc_device #(
  parameter int POR_CYCLES = `RSC_POR_CYCLES,
  parameter int RESET_LOW_CYCLES = `RSC_RESET_LOW_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  rsc_link_if.device link,
  input wire logic secondary_supply_ok,
  input wire logic conversion_tick,
  output logic converter_enable,
  output logic [3:0] converter_frequency_field,
  output logic sync_event,
  output logic device_in_reset
);
  localparam int FRAME_BITS = `RSC_WORD_BITS * `RSC_FRAME_WORDS;
  localparam int CRC_BITS =
    (`RSC_ADDR_CRC_LAST - `RSC_ADDR_CRC_FIRST + 1) * `RSC_WORD_BITS;

  // The counters below are sized for these ranges.
  initial begin
    if (POR_CYCLES < 1 || POR_CYCLES > 4095) begin
      $error("POR_CYCLES out of range");
    end
    if (RESET_LOW_CYCLES <= `RSC_SYNC_MIN_CYCLES ||
        RESET_LOW_CYCLES > 4095) begin
      $error("RESET_LOW_CYCLES out of range");
    end
  end

  // Asynchronous inputs: sclk, cs_n, mosi, pin, supply good.
  logic [4:0] meta_r; // First stage, read only by sync_r.
  logic [4:0] sync_r; // Second stage, safe to use.
  logic [4:0] prev_r; // Delayed copy for edge detection.
  logic [15:0] map_r [`RSC_ADDR_CRC_FIRST:`RSC_ADDR_CRC_LAST];
  logic [11:0] por_cnt_r; // Power-on interval counter.
  logic [11:0] low_cnt_r; // Cycles the pin has been low.
  logic pin_hold_r; // Pin reset in force.
  logic cmd_rst_r; // One-cycle reset from a command.
  logic [6:0] bit_cnt_r; // Bits received in this frame.
  logic [15:0] rx_r; // Receive shift register.
  logic [15:0] cmd_r; // First word of the frame.
  logic [15:0] data_r; // Second word of the frame.
  logic [15:0] tx_r; // Reply shift register.
  logic miso_r;
  logic miso_oe_r;
  logic data_ready_n_n_r;
  logic out_pin_r;
  logic out_oe_r;
  logic [9:0] crc_idx_r; // Bit position in the covered space.
  logic [15:0] crc_r; // Running check value.
  logic [15:0] check_r; // Last finished check value.
  logic map_chg_r; // Map-changed flag.
  logic secondary_supply_fail_r; // Latched secondary supply fail.
  logic conv_en_r;
  logic [3:0] conv_freq_r;
  logic sync_ev_r;
  logic in_rst_r;

  wire sclk_s = sync_r[0];
  wire cs_n_s = sync_r[1];
  wire mosi_s = sync_r[2];
  wire pin_n_s = sync_r[3];
  wire supply_ok_s = sync_r[4];
  wire sclk_rise = sclk_s & ~prev_r[0];
  wire sclk_fall = ~sclk_s & prev_r[0];
  wire cs_fall = ~cs_n_s & prev_r[1];
  wire cs_rise = cs_n_s & ~prev_r[1];
  wire pin_rise = pin_n_s & ~prev_r[3];
  wire por_done = (por_cnt_r == 12'(POR_CYCLES));
  // Power-on, pin and command resets all restore defaults.
  wire any_rst = rst | pin_hold_r | cmd_rst_r;
  // Serial traffic is only heard once the device is ready.
  wire spi_ok = por_done & ~pin_hold_r & ~cmd_rst_r;
  wire [15:0] word_in = {rx_r[14:0], mosi_s};
  wire is_read = (word_in[15:13] == `RSC_CMD_READ_TOP);
  wire [5:0] word_addr = word_in[12:7];
  wire frame_full = (bit_cnt_r == 7'(FRAME_BITS));
  wire word0_end = sclk_rise & ~cs_n_s & spi_ok & (bit_cnt_r == 7'd15);
  // A null command or a read of status returns the status word.
  wire stat_read = word0_end & ((word_in == `RSC_CMD_NULL) |
    (is_read & (word_addr == `RSC_ADDR_STATUS)));
  wire [5:0] crc_addr = 6'(`RSC_ADDR_CRC_FIRST + crc_idx_r[9:4]);
  wire crc_bit = map_r[crc_addr][~crc_idx_r[3:0]];
  wire crc_fb = crc_bit ^ crc_r[15];
  wire [15:0] poly = map_r[`RSC_ADDR_MODE][`RSC_MODE_CRC_TYPE] ?
    `RSC_POLY_ANSI : `RSC_POLY_CCITT;
  wire [15:0] crc_nxt = {crc_r[14:0], 1'b0} ^ (crc_fb ? poly : 16'h0000);
  wire crc_on = map_r[`RSC_ADDR_MODE][`RSC_MODE_CRC_EN];
  wire crc_last = (crc_idx_r == 10'(CRC_BITS - 1));
  wire crc_changed = crc_on & crc_last & (crc_nxt != check_r);

  // Reply word for a read address; unmapped addresses read zero.
  function automatic logic [15:0] read_word(input logic [5:0] a);
    logic [15:0] w;
    w = 16'h0000;
    if (a == `RSC_ADDR_ID) begin
      w = `RSC_ID_VALUE;
    end else if (a == `RSC_ADDR_STATUS) begin
      w[`RSC_STAT_MAP_CHG] = map_chg_r;
      w[`RSC_STAT_SECONDARY_SUPPLY_FAIL] = secondary_supply_fail_r;
    end else if (a == `RSC_ADDR_CHECK) begin
      w = check_r;
    end else if (a >= `RSC_ADDR_CRC_FIRST && a <= `RSC_ADDR_CRC_LAST) begin
      w = map_r[a];
    end
    return w;
  endfunction : read_word

  // Two-stage synchroniser; idle levels are select and pin high.
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_r <= 5'h0A;
      sync_r <= 5'h0A;
      prev_r <= 5'h0A;
    end else begin
      meta_r <= {secondary_supply_ok, link.sync_reset_n, link.mosi,
        link.cs_n, link.sclk};
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  // Power-on interval; only the power-on reset restarts it.
  always_ff @(posedge clk) begin
    if (rst) begin
      por_cnt_r <= 12'h000;
    end else if (!por_done) begin
      por_cnt_r <= por_cnt_r + 12'h001;
    end
  end

  // Pin width measurement: long lows reset, short lows synchronise.
  always_ff @(posedge clk) begin
    if (rst) begin
      low_cnt_r <= 12'h000;
      pin_hold_r <= 1'b0;
      sync_ev_r <= 1'b0;
    end else begin
      sync_ev_r <= 1'b0;
      if (pin_n_s) begin
        low_cnt_r <= 12'h000;
        pin_hold_r <= 1'b0;
        if (pin_rise && !pin_hold_r &&
            low_cnt_r >= 12'(`RSC_SYNC_MIN_CYCLES)) begin
          sync_ev_r <= 1'b1;
        end
      end else if (low_cnt_r < 12'(RESET_LOW_CYCLES)) begin
        low_cnt_r <= low_cnt_r + 12'h001;
      end else begin
        pin_hold_r <= 1'b1;
      end
    end
  end

  // Frame receiver; writes and reset act only at a full frame end.
  always_ff @(posedge clk) begin
    if (any_rst) begin
      bit_cnt_r <= 7'h00;
      rx_r <= 16'h0000;
      cmd_r <= 16'h0000;
      data_r <= 16'h0000;
      cmd_rst_r <= 1'b0;
    end else begin
      cmd_rst_r <= 1'b0;
      if (cs_fall) begin
        bit_cnt_r <= 7'h00;
      end else if (sclk_rise && !cs_n_s && spi_ok && !frame_full) begin
        rx_r <= word_in;
        bit_cnt_r <= bit_cnt_r + 7'h01;
        if (bit_cnt_r == 7'd15) begin
          cmd_r <= word_in;
        end
        if (bit_cnt_r == 7'd31) begin
          data_r <= word_in;
        end
      end
      // A short frame leaves the command unexecuted.
      if (cs_rise && frame_full && cmd_r == `RSC_CMD_RESET) begin
        cmd_rst_r <= 1'b1;
      end
    end
  end

  // Writable map; each entry returns to its default on any reset.
  for (genvar a = `RSC_ADDR_CRC_FIRST; a <= `RSC_ADDR_CRC_LAST; a++) begin : g_map
    always_ff @(posedge clk) begin
      if (any_rst) begin
        map_r[a] <= (a == `RSC_ADDR_CLOCK) ? `RSC_RST_CLOCK
          : `RSC_RST_WORD;
      end else if (cs_rise && frame_full &&
          cmd_r[15:13] == `RSC_CMD_WRITE_TOP && cmd_r[12:7] == 6'(a)) begin
        map_r[a] <= data_r;
      end
    end
  end

  // Reply shifter: loaded after word one, shifted on falling sclk.
  always_ff @(posedge clk) begin
    if (any_rst) begin
      tx_r <= 16'h0000;
      miso_r <= 1'b0;
      miso_oe_r <= 1'b0;
    end else begin
      miso_oe_r <= ~cs_n_s & spi_ok;
      if (cs_fall) begin
        tx_r <= 16'h0000;
        miso_r <= 1'b0;
      end else if (word0_end) begin
        tx_r <= is_read ? read_word(word_addr)
          : read_word(`RSC_ADDR_STATUS);
      end else if (sclk_fall && !cs_n_s) begin
        miso_r <= tx_r[15];
        tx_r <= {tx_r[14:0], 1'b0};
      end
    end
  end

  // Serial map check; runs without pause while enabled.
  always_ff @(posedge clk) begin
    if (any_rst) begin
      crc_idx_r <= 10'h000;
      crc_r <= `RSC_CRC_SEED;
      check_r <= `RSC_RST_CHECK;
    end else if (!crc_on) begin
      crc_idx_r <= 10'h000;
      crc_r <= `RSC_CRC_SEED;
    end else if (crc_last) begin
      check_r <= crc_nxt;
      crc_idx_r <= 10'h000;
      crc_r <= `RSC_CRC_SEED;
    end else begin
      crc_idx_r <= crc_idx_r + 10'h001;
      crc_r <= crc_nxt;
    end
  end

  // Status flags; a new event wins over the clear by a status read.
  always_ff @(posedge clk) begin
    if (any_rst) begin
      map_chg_r <= 1'b0;
      secondary_supply_fail_r <= 1'b1;
    end else begin
      if (crc_changed) begin
        map_chg_r <= 1'b1;
      end else if (stat_read) begin
        map_chg_r <= 1'b0;
      end
      if (!supply_ok_s || !conv_en_r) begin
        secondary_supply_fail_r <= 1'b1;
      end else if (stat_read) begin
        secondary_supply_fail_r <= 1'b0;
      end
    end
  end

  // Data ready: low through power-on, then high; conversions pull it
  // low only while the converter is enabled, a frame releases it.
  always_ff @(posedge clk) begin
    if (rst || !por_done) begin
      data_ready_n_n_r <= !rst && por_cnt_r == 12'(POR_CYCLES - 1);
    end else if (pin_hold_r || cmd_rst_r || cs_fall) begin
      data_ready_n_n_r <= 1'b1;
    end else if (conversion_tick && conv_en_r) begin
      data_ready_n_n_r <= 1'b0;
    end
  end

  // Registered outputs from the configuration words.
  always_ff @(posedge clk) begin
    if (any_rst) begin
      out_pin_r <= 1'b0;
      out_oe_r <= 1'b0;
      conv_en_r <= 1'b0;
      conv_freq_r <= 4'h0;
      in_rst_r <= 1'b1;
    end else begin
      out_oe_r <= map_r[`RSC_ADDR_CFG][`RSC_CFG_OUT_EN];
      out_pin_r <= map_r[`RSC_ADDR_CFG][`RSC_CFG_OUT_EN] &
        map_r[`RSC_ADDR_CFG][`RSC_CFG_OUT_LVL];
      conv_en_r <= map_r[`RSC_ADDR_CONV][`RSC_CONV_EN];
      conv_freq_r <= map_r[`RSC_ADDR_CONV][`RSC_CONV_FREQ_LSB +: 4];
      in_rst_r <= 1'b0;
    end
  end

  assign link.miso = miso_r;
  assign link.miso_oe = miso_oe_r;
  assign link.data_ready_n = data_ready_n_n_r;
  assign link.general_output_pin = out_pin_r;
  assign link.general_output_oe = out_oe_r;
  assign converter_enable = conv_en_r;
  assign converter_frequency_field = conv_freq_r;
  assign sync_event = sync_ev_r;
  assign device_in_reset = in_rst_r;
endmodule : rsc_device

// file: logic/rsc_host.sv
`timescale 1ns/100ps
`include "rsc_regs.svh"
module rsc_host #(
  parameter int SCLK_HALF = `RSC_SCLK_HALF,
  parameter int REG_ACQ_CYCLES = `RSC_REG_ACQ_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  rsc_link_if.host link,
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata
);
  localparam int FRAME_BITS = `RSC_WORD_BITS * `RSC_FRAME_WORDS;

  // The device needs several of our cycles per serial half period.
  initial begin
    if (SCLK_HALF < 8 || SCLK_HALF > 255) begin
      $error("SCLK_HALF out of range");
    end
    if (REG_ACQ_CYCLES < `RSC_FRAME_GAP || REG_ACQ_CYCLES > 4095) begin
      $error("REG_ACQ_CYCLES out of range");
    end
  end

  rsc_pkg::rsc_host_state_t state_r;
  logic [1:0] meta_r; // First stage of miso and data ready.
  logic [1:0] sync_r; // Second stage.
  logic [79:0] tx_r; // Outgoing frame, word one first.
  logic [15:0] data_r; // Second word for writes.
  logic [15:0] resp_r; // Reply captured from word two.
  logic [6:0] bit_cnt_r;
  logic [7:0] div_r; // Half-period divider.
  logic [11:0] wait_r; // Gap or acquisition wait.
  logic sclk_r;
  logic cs_n_r;
  logic pin_low_r;
  logic [15:0] rdata_r;

  wire busy = (state_r != rsc_pkg::RSC_H_IDLE) | pin_low_r;
  wire half_done = (div_r == 8'(SCLK_HALF - 1));
  wire last_bit = (bit_cnt_r == 7'(FRAME_BITS - 1));
  wire pin_release = wr & (addr == `RSC_HADDR_PIN) & ~wdata[0] & pin_low_r;

  // Synchroniser for the device outputs we read.
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_r <= 2'h2;
      sync_r <= 2'h2;
    end else begin
      meta_r <= {link.data_ready_n, link.miso};
      sync_r <= meta_r;
    end
  end

  // Frame engine: software orders frames one at a time through the
  // command register; commands while busy are dropped.
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= rsc_pkg::RSC_H_IDLE;
      tx_r <= 80'h0;
      bit_cnt_r <= 7'h00;
      div_r <= 8'h00;
      wait_r <= 12'h000;
      sclk_r <= 1'b0;
      cs_n_r <= 1'b1;
      resp_r <= 16'h0000;
    end else begin
      unique case (state_r)
        rsc_pkg::RSC_H_IDLE: begin
          if (pin_release) begin
            wait_r <= 12'(REG_ACQ_CYCLES);
            state_r <= rsc_pkg::RSC_H_SETTLE;
          end else if (wr && addr == `RSC_HADDR_CMD && !pin_low_r) begin
            tx_r <= {wdata, data_r, 48'h0};
            // Reset frames end in the long wait.
            wait_r <= (wdata == `RSC_CMD_RESET) ? 12'(REG_ACQ_CYCLES)
              : 12'(`RSC_FRAME_GAP);
            cs_n_r <= 1'b0;
            bit_cnt_r <= 7'h00;
            div_r <= 8'h00;
            state_r <= rsc_pkg::RSC_H_SHIFT;
          end
        end
        rsc_pkg::RSC_H_SHIFT: begin
          div_r <= half_done ? 8'h00 : div_r + 8'h01;
          if (half_done && !sclk_r) begin
            sclk_r <= 1'b1;
            if (bit_cnt_r >= 7'd16 && bit_cnt_r < 7'd32) begin
              resp_r <= {resp_r[14:0], sync_r[0]};
            end
          end else if (half_done) begin
            sclk_r <= 1'b0;
            bit_cnt_r <= bit_cnt_r + 7'h01;
            // All five words go out before select rises.
            if (last_bit) begin
              cs_n_r <= 1'b1;
              state_r <= rsc_pkg::RSC_H_SETTLE;
            end else begin
              tx_r <= {tx_r[78:0], 1'b0};
            end
          end
        end
        rsc_pkg::RSC_H_SETTLE: begin
          if (wait_r == 12'h000) begin
            state_r <= rsc_pkg::RSC_H_IDLE;
          end else begin
            wait_r <= wait_r - 12'h001;
          end
        end
      endcase
    end
  end

  // Software registers: second word and the reset pin drive.
  always_ff @(posedge clk) begin
    if (rst) begin
      data_r <= 16'h0000;
      pin_low_r <= 1'b0;
    end else if (wr && addr == `RSC_HADDR_DATA) begin
      data_r <= wdata;
    end else if (wr && addr == `RSC_HADDR_PIN &&
        state_r != rsc_pkg::RSC_H_SHIFT) begin
      pin_low_r <= wdata[0];
    end
  end

  // Read data stand only in the cycle after the strobe.
  always_ff @(posedge clk) begin
    if (rst || !rd) begin
      rdata_r <= 16'h0000;
    end else if (addr == `RSC_HADDR_RESP) begin
      rdata_r <= resp_r;
    end else if (addr == `RSC_HADDR_STAT) begin
      rdata_r <= {13'h0000, pin_low_r, sync_r[1], busy};
    end else if (addr == `RSC_HADDR_DATA) begin
      rdata_r <= data_r;
    end else if (addr == `RSC_HADDR_PIN) begin
      rdata_r <= {15'h0000, pin_low_r};
    end else begin
      rdata_r <= 16'h0000;
    end
  end

  assign link.sclk = sclk_r;
  assign link.cs_n = cs_n_r;
  assign link.mosi = tx_r[79];
  assign link.sync_reset_n = ~pin_low_r;
  assign rdata = rdata_r;
endmodule : rsc_host

// file: verification/rsc_link_asserts.sv
`timescale 1ns/100ps
// Watches the link between the two ends; all inputs but clk and rst are link signals.
module rsc_link_asserts #(
  parameter int RESET_LOW_CYCLES = 200
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso,
  input wire logic sync_reset_n,
  input wire logic data_ready_n,
  input wire logic general_output_oe,
  input wire logic general_output_pin
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic sclk_q_r; // Last sampled serial clock.
  logic [6:0] bits_r; // Serial clock rises in the current frame.
  logic [15:0] word_r; // First word seen on mosi.
  logic [7:0] low_r; // Cycles the pin has been low, saturating.
  // Edge finder for the serial clock.
  always_ff @(posedge clk) begin
    sclk_q_r <= sclk;
  end
  // Bit counter; it restarts whenever the frame select is high.
  always_ff @(posedge clk) begin
    if (rst || cs_n) begin
      bits_r <= '0;
    end else if (sclk && !sclk_q_r) begin
      bits_r <= bits_r + 7'h01;
    end
  end
  // Only the first sixteen bits matter for the command word.
  always_ff @(posedge clk) begin
    if (!cs_n && sclk && !sclk_q_r && bits_r < 7'h10) begin
      word_r <= {word_r[14:0], mosi};
    end
  end
  // Saturation keeps a long hold from wrapping back to a short one.
  always_ff @(posedge clk) begin
    if (rst || sync_reset_n) begin
      low_r <= '0;
    end else if (low_r != 8'hFF) begin
      low_r <= low_r + 8'h01;
    end
  end
  sequence s_reset_cmd;
    $rose(cs_n) && bits_r == 7'h50 && word_r == 16'h0011;
  endsequence
  sequence s_por_low;
    !data_ready_n [*8];
  endsequence
  property p_cs_gap; $rose(cs_n) |-> cs_n [*4]; endproperty
  property p_sclk_frame; sclk |-> !cs_n; endproperty
  property p_miso_stable; sclk && $past(sclk) |-> $stable(miso); endproperty
  property p_frame_bits; $rose(cs_n) |-> bits_r == 7'h50; endproperty
  property p_gpo_rst;
    $fell(rst) |-> !general_output_oe && !general_output_pin;
  endproperty
  property p_data_ready_n_por; $fell(rst) |-> s_por_low ##[1:6] data_ready_n; endproperty
  property p_cmd_reset; s_reset_cmd |-> ##[1:6] !general_output_oe; endproperty
  property p_pin_reset;
    low_r > RESET_LOW_CYCLES + 8 |-> !general_output_oe;
  endproperty
  property p_pin_acq; $rose(sync_reset_n) |-> cs_n [*8]; endproperty
  a_cs_gap: assert property (p_cs_gap)
    else $error("frame select gap too short");
  a_sclk_frame: assert property (p_sclk_frame)
    else $error("serial clock high outside a frame");
  a_miso_stable: assert property (p_miso_stable)
    else $error("reply bit moved while serial clock high");
  a_frame_bits: assert property (p_frame_bits)
    else $error("frame not five words long");
  a_gpo_rst: assert property (p_gpo_rst)
    else $error("output pin active after reset");
  a_data_ready_n_por: assert property (p_data_ready_n_por)
    else $error("data ready timing wrong after power-on");
  a_cmd_reset: assert property (p_cmd_reset)
    else $error("reset command did not restore defaults");
  a_pin_reset: assert property (p_pin_reset)
    else $error("long pin hold did not reset");
  a_pin_acq: assert property (p_pin_acq)
    else $error("frame started too soon after pin release");
endmodule : rsc_link_asserts

// file: verification/test_reset_startup_regcrc_control.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin err_count++; \
  $display("MISMATCH %s exp %h got %h", nm, e, g); end end
// Host and device face each other; the bench drives the host command port.
module test_reset_startup_regcrc_control;
  logic clk, rst, wr, rd, tick, conv_en, sync_ev, in_rst, saw_rst, sup_ok;
  logic [3:0] addr, freq;
  logic [15:0] wdata, rdata, resp;
  logic [15:0] m [0:63]; // Expected device register contents.
  int err_count, n_checks;
  rsc_link_if link();
  rsc_device #(.POR_CYCLES(10), .RESET_LOW_CYCLES(20)) rsc_device_i (
    .clk(clk), .rst(rst), .link(link), .secondary_supply_ok(sup_ok),
    .conversion_tick(tick), .converter_enable(conv_en),
    .converter_frequency_field(freq), .sync_event(sync_ev),
    .device_in_reset(in_rst));
  rsc_host #(.SCLK_HALF(8), .REG_ACQ_CYCLES(8)) rsc_host_i (.clk(clk),
    .rst(rst), .link(link), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata));
  rsc_link_asserts #(.RESET_LOW_CYCLES(20)) rsc_link_asserts_i (.clk(clk),
    .rst(rst), .sclk(link.sclk), .cs_n(link.cs_n), .mosi(link.mosi),
    .miso(link.miso), .sync_reset_n(link.sync_reset_n),
    .data_ready_n(link.data_ready_n),
    .general_output_oe(link.general_output_oe),
    .general_output_pin(link.general_output_pin));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Remembers any device reset between two looks.
  always @(posedge clk) if (in_rst) saw_rst <= 1'b1;
  task automatic stop_test;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test
  task automatic hwr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : hwr
  // Read data stand only in the cycle after the strobe.
  task automatic hrd(input logic [3:0] a, output logic [15:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    v = rdata;
  endtask : hrd
  // One whole frame; a hung host ends the run as a failure.
  task automatic frame(input logic [15:0] c, input logic [15:0] d);
    logic [15:0] s;
    hwr(4'h1, d);
    hwr(4'h0, c);
    repeat (3) @(posedge clk);
    s = 16'hFFFF;
    for (int n = 0; n < 3000 && s[0] !== 1'b0; n++) hrd(4'h3, s);
    if (s[0] !== 1'b0) begin
      err_count++;
      stop_test;
    end
    hrd(4'h2, resp);
  endtask : frame
  task automatic wreg(input logic [5:0] a, input logic [15:0] d);
    frame({3'h3, a, 7'h00}, d);
    m[a] = d;
  endtask : wreg
  task automatic rreg(input logic [5:0] a, output logic [15:0] v);
    frame({3'h5, a, 7'h00}, 16'h0000);
    v = resp;
  endtask : rreg
  task automatic mreset;
    foreach (m[i]) m[i] = 16'h0000;
    m[3] = 16'h0003;
  endtask : mreset
  // Serial check over the map, most significant bit first.
  function automatic logic [15:0] crc_m(input logic [15:0] poly);
    logic [15:0] c;
    c = 16'hFFFF;
    for (int a = 2; a <= 49; a++)
      for (int b = 15; b >= 0; b--)
        c = {c[14:0], 1'b0} ^ ((c[15] ^ m[a][b]) ? poly : 16'h0000);
    return c;
  endfunction : crc_m
  task automatic pulse_tick;
    @(posedge clk);
    tick <= 1'b1;
    @(posedge clk);
    tick <= 1'b0;
  endtask : pulse_tick
  task automatic t_por;
    `CHK("data_ready_n_low", 1'b0, link.data_ready_n);
    for (int n = 0; n < 200 && link.data_ready_n !== 1'b1; n++)
      @(negedge clk);
    `CHK("data_ready_n_up", 1'b1, link.data_ready_n);
    `CHK("conv_off", 1'b0, conv_en);
  endtask : t_por
  task automatic t_gpo;
    for (int i = 1; i < 4; i += 2) begin
      wreg(6'h04, 16'(i));
      `CHK("gpo_oe", 1'b1, link.general_output_oe);
      `CHK("gpo_lvl", i[1], link.general_output_pin);
    end
  endtask : t_gpo
  // Data ready stays quiet until the converter is enabled.
  task automatic t_conv;
    logic [15:0] v;
    pulse_tick;
    repeat (4) @(negedge clk);
    `CHK("no_data", 1'b1, link.data_ready_n);
    wreg(6'h05, 16'h0051);
    `CHK("conv_en", 1'b1, conv_en);
    `CHK("freq", 4'h5, freq);
    repeat (2) rreg(6'h01, v);
    `CHK("fail_latched", 1'b1, v[1]);
    @(posedge clk);
    sup_ok <= 1'b1;
    for (int n = 0; n < 10 && v[1] !== 1'b0; n++) rreg(6'h01, v);
    `CHK("fail_clear", 1'b0, v[1]);
    frame(16'h0000, 16'h0000);
    `CHK("null_stat", 1'b0, resp[1]);
    pulse_tick;
    for (int n = 0; n < 8 && link.data_ready_n !== 1'b0; n++) @(negedge clk);
    `CHK("data", 1'b0, link.data_ready_n);
  endtask : t_conv
  // Both check types, then a flag set by a plain write.
  task automatic t_crc;
    logic [15:0] v;
    for (int t = 0; t < 2; t++) begin
      wreg(6'h02, {14'h0000, t[0], 1'b1});
      repeat (1700) @(posedge clk);
      rreg(6'h3E, v);
      `CHK("check", crc_m(t ? 16'h8005 : 16'h1021), v);
      rreg(6'h01, v);
      `CHK("chg_set", 1'b1, v[0]);
      rreg(6'h01, v);
      `CHK("chg_clr", 1'b0, v[0]);
    end
    wreg(6'h06, 16'hA5A5);
    repeat (1700) @(posedge clk);
    frame(16'h0000, 16'h0000);
    `CHK("null_set", 1'b1, resp[0]);
    frame(16'h0000, 16'h0000);
    `CHK("null_clr", 1'b0, resp[0]);
  endtask : t_crc
  task automatic t_reset_cmd;
    logic [15:0] v;
    @(posedge clk);
    saw_rst <= 1'b0;
    frame(16'h0011, 16'h0000);
    mreset;
    `CHK("cmd_rst", 1'b1, saw_rst);
    `CHK("cmd_conv", 1'b0, conv_en);
    `CHK("cmd_gpo", 1'b0, link.general_output_oe);
    rreg(6'h05, v);
    `CHK("conv_reg", 16'h0000, v);
    rreg(6'h03, v);
    `CHK("clock_reg", 16'h0003, v);
    rreg(6'h3E, v);
    `CHK("check_rst", 16'h0000, v);
  endtask : t_reset_cmd
  // A short pulse synchronises; a long hold resets until release.
  task automatic t_pin;
    wreg(6'h05, 16'h0051);
    wreg(6'h04, 16'h0001);
    @(posedge clk);
    saw_rst <= 1'b0;
    hwr(4'h4, 16'h0001);
    repeat (8) @(posedge clk);
    hwr(4'h4, 16'h0000);
    for (int n = 0; n < 20 && sync_ev !== 1'b1; n++) @(negedge clk);
    `CHK("sync", 1'b1, sync_ev);
    `CHK("no_rst", 1'b0, saw_rst);
    hwr(4'h4, 16'h0001);
    repeat (40) @(negedge clk);
    `CHK("pin_rst", 1'b1, in_rst);
    `CHK("pin_conv", 1'b0, conv_en);
    hwr(4'h4, 16'h0000);
    repeat (30) @(negedge clk);
    `CHK("pin_out", 1'b0, in_rst);
  endtask : t_pin
  initial begin
    rst = 1'b1;
    {wr, rd, tick, saw_rst, sup_ok} = 5'h0;
    addr = 4'h0;
    wdata = 16'h0000;
    err_count = 0;
    n_checks = 0;
    mreset;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    t_por;
    t_gpo;
    t_conv;
    t_crc;
    t_reset_cmd;
    t_pin;
    stop_test;
  end
endmodule : test_reset_startup_regcrc_control
